// >>> design/scs_pkg.sv
// Constants and types for the serial configuration slave port.
// Assumes a 25 MHz system clock that oversamples the serial clock pin.
package scs_pkg;
    localparam int          SCS_NUM_BYTES  = 32;
    localparam int          SCS_IDX_W      = 7;
    localparam logic [6:0]  SCS_SLAVE_ADDR = 7'h69;
    localparam logic [7:0]  SCS_CFG_RESET  = 8'hff;
    localparam int          SCS_CMD_TYPE_BIT = 7;
    localparam logic [3:0]  SCS_BIT_LAST   = 4'h7;
    localparam logic [3:0]  SCS_BIT_ACK    = 4'h8;
    localparam logic [3:0]  SCS_BIT_PRE    = 4'hf;

    typedef enum logic [2:0] {
        SCS_IDLE  = 3'b000,
        SCS_ADDR  = 3'b001,
        SCS_CMD   = 3'b010,
        SCS_WDATA = 3'b011,
        SCS_RDATA = 3'b100,
        SCS_SKIP  = 3'b101
    } scs_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } scs_pins_t;
endpackage

// >>> design/scs_slave.sv
// Serial configuration slave: register bank behind a two-wire slave port.
// Assumes serial pins come asynchronously; an outside pad resolves the open-drain wire.
`timescale 1ns/1ps
module scs_slave
    import scs_pkg::*;
#(
    parameter int NUM_BYTES = SCS_NUM_BYTES
)
(
    // Clock and reset
    input  wire logic                   ref_clk_i,
    input  wire logic                   rst_b_i,
    // Serial pins
    input  wire logic                   serial_clk_i,
    input  wire logic                   serial_data_pin_i,
    output logic                        serial_data_pin_o,
    output logic                        serial_data_pin_oe_o,
    // Power control
    input  wire logic                   power_down_n_i,
    output logic                        power_down_o,
    // Configuration image
    output logic [NUM_BYTES*8-1:0]      cfg_bytes_o
);
    logic       rst_m;
    logic       rst_s;
    scs_pins_t  pin_s1;
    scs_pins_t  pin_s2;
    scs_pins_t  pin_s3;
    logic       pd_s1;
    logic       pd_s2;
    logic       pd_s3;
    scs_pins_t  pin_q;
    scs_pins_t  next_pin_q;

    // Reset release
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    // Three-stage pin synchronisers
    always_ff @(posedge ref_clk_i or negedge rst_s)
    begin
        if (!rst_s)
        begin
            pin_s1 <= '{scl: 1'b1, sda: 1'b1};
            pin_s2 <= '{scl: 1'b1, sda: 1'b1};
            pin_s3 <= '{scl: 1'b1, sda: 1'b1};
            pd_s1  <= 1'b1;
            pd_s2  <= 1'b1;
            pd_s3  <= 1'b1;
            pin_q  <= '{scl: 1'b1, sda: 1'b1};
        end
        else
        begin
            pin_s1 <= '{scl: serial_clk_i, sda: serial_data_pin_i};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pd_s1  <= power_down_n_i;
            pd_s2  <= pd_s1;
            pd_s3  <= pd_s2;
            pin_q  <= next_pin_q;
        end
    end

    // Filtered levels: change taken once stages two and three agree
    always_comb
    begin
        next_pin_q = pin_q;
        if (pin_s2.scl == pin_s3.scl)
            next_pin_q.scl = pin_s3.scl;
        if (pin_s2.sda == pin_s3.sda)
            next_pin_q.sda = pin_s3.sda;
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    assign scl_rise  = !pin_q.scl && next_pin_q.scl;
    assign scl_fall  = pin_q.scl && !next_pin_q.scl;
    assign start_det = pin_q.scl && next_pin_q.scl && pin_q.sda && !next_pin_q.sda;
    assign stop_det  = pin_q.scl && next_pin_q.scl && !pin_q.sda && next_pin_q.sda;

    // Power-down level
    logic pd_act;
    logic next_pd_act;
    always_comb
    begin
        next_pd_act = pd_act;
        if (pd_s2 == pd_s3)
            next_pd_act = !pd_s3;
    end

    // Protocol state
    scs_state_t           state;
    scs_state_t           next_state;
    logic [3:0]           bit_cnt;
    logic [3:0]           next_bit_cnt;
    logic [7:0]           shreg;
    logic [7:0]           next_shreg;
    logic                 rd_dir;
    logic                 next_rd_dir;
    logic                 blk;
    logic                 next_blk;
    logic                 cnt_phase;
    logic                 next_cnt_phase;
    logic [SCS_IDX_W-1:0] ptr;
    logic [SCS_IDX_W-1:0] next_ptr;
    logic                 sda_low;
    logic                 next_sda_low;
    logic                 host_nack;
    logic                 next_host_nack;
    logic [7:0]           cfg [NUM_BYTES];
    logic [7:0]           next_cfg [NUM_BYTES];
    logic [7:0]           rd_byte;
    logic                 in_range;
    localparam int        IDX_AW = $clog2(NUM_BYTES);
    logic [IDX_AW-1:0]    ptr_idx;

    assign ptr_idx  = ptr[IDX_AW-1:0];
    assign in_range = ptr < SCS_IDX_W'(NUM_BYTES);
    assign rd_byte  = cnt_phase ? 8'(NUM_BYTES) : (in_range ? cfg[ptr_idx] : 8'h00);

    always_comb
    begin
        next_state     = state;
        next_bit_cnt   = bit_cnt;
        next_shreg     = shreg;
        next_rd_dir    = rd_dir;
        next_blk       = blk;
        next_cnt_phase = cnt_phase;
        next_ptr       = ptr;
        next_sda_low   = sda_low;
        next_host_nack = host_nack;
        next_cfg       = cfg;
        if (stop_det)
        begin
            next_state   = SCS_IDLE;
            next_sda_low = 1'b0;
        end
        else if (start_det)
        begin
            next_state   = SCS_ADDR;
            next_bit_cnt = SCS_BIT_PRE;
            next_sda_low = 1'b0;
        end
        else if (scl_rise && state != SCS_IDLE && state != SCS_SKIP)
        begin
            if (bit_cnt <= SCS_BIT_LAST)
                next_shreg = {shreg[6:0], pin_q.sda};
            else if (state == SCS_RDATA)
                next_host_nack = pin_q.sda;
        end
        else if (scl_fall && state != SCS_IDLE && state != SCS_SKIP)
        begin
            next_sda_low = 1'b0;
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == SCS_BIT_LAST)
            begin
                case (state)
                    SCS_ADDR:
                    begin
                        if (shreg[7:1] == SCS_SLAVE_ADDR)
                        begin
                            next_sda_low = 1'b1;
                            next_rd_dir  = shreg[0];
                        end
                        else
                            next_state = SCS_SKIP;
                    end
                    SCS_CMD:
                    begin
                        next_sda_low   = 1'b1;
                        next_blk       = !shreg[SCS_CMD_TYPE_BIT];
                        next_cnt_phase = !shreg[SCS_CMD_TYPE_BIT];
                        next_ptr       = shreg[SCS_CMD_TYPE_BIT] ?
                                         shreg[SCS_IDX_W-1:0] : '0;
                    end
                    SCS_WDATA:
                    begin
                        next_sda_low = 1'b1;
                        if (cnt_phase)
                            next_cnt_phase = 1'b0;
                        else
                        begin
                            if (in_range)
                                next_cfg[ptr_idx] = shreg;
                            next_ptr = ptr + 1'b1;
                        end
                    end
                    SCS_RDATA:
                    begin
                        if (cnt_phase)
                            next_cnt_phase = 1'b0;
                        else
                            next_ptr = ptr + 1'b1;
                    end
                    default:
                        next_state = SCS_SKIP;
                endcase
            end
            else if (bit_cnt == SCS_BIT_ACK)
            begin
                next_bit_cnt = 4'h0;
                case (state)
                    SCS_ADDR:
                        next_state = rd_dir ? SCS_RDATA : SCS_CMD;
                    SCS_CMD:
                        next_state = SCS_WDATA;
                    SCS_RDATA:
                        if (host_nack)
                            next_state = SCS_SKIP;
                    default:
                        next_state = state;
                endcase
            end
            if (next_state == SCS_RDATA && next_bit_cnt <= SCS_BIT_LAST)
                next_sda_low = !rd_byte[3'(SCS_BIT_LAST - next_bit_cnt)];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_s)
    begin
        if (!rst_s)
        begin
            state     <= SCS_IDLE;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            rd_dir    <= 1'b0;
            blk       <= 1'b0;
            cnt_phase <= 1'b0;
            ptr       <= '0;
            sda_low   <= 1'b0;
            host_nack <= 1'b0;
            pd_act    <= 1'b0;
            for (int i = 0; i < NUM_BYTES; i++)
                cfg[i] <= SCS_CFG_RESET;
        end
        else
        begin
            state     <= next_state;
            bit_cnt   <= next_bit_cnt;
            shreg     <= next_shreg;
            rd_dir    <= next_rd_dir;
            blk       <= next_blk;
            cnt_phase <= next_cnt_phase;
            ptr       <= next_ptr;
            sda_low   <= next_sda_low;
            host_nack <= next_host_nack;
            pd_act    <= next_pd_act;
            cfg       <= next_cfg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_BYTES; g++)
        begin : g_cfg
            assign cfg_bytes_o[g*8 +: 8] = cfg[g];
        end
    endgenerate

    assign serial_data_pin_o    = 1'b0;
    assign serial_data_pin_oe_o = sda_low;
    assign power_down_o         = pd_act;

    chk_pd_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_s)
        (pd_s2 == pd_s3) |=> (pd_act == !$past(pd_s3)))
        else $error("power-down not following input");
    chk_skip_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_s)
        (state == SCS_SKIP && !start_det) |=> !sda_low)
        else $error("drives data while ignoring bus");
    chk_addr_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_s)
        (state == SCS_ADDR && scl_fall && bit_cnt == SCS_BIT_LAST && !start_det && !stop_det
         && shreg[7:1] == SCS_SLAVE_ADDR) |=> sda_low)
        else $error("matching address not acknowledged");
    chk_cmd_decode: assert property (@(posedge ref_clk_i) disable iff (!rst_s)
        (state == SCS_CMD && scl_fall && bit_cnt == SCS_BIT_LAST && !start_det && !stop_det)
        |=> (blk == !$past(shreg[7])))
        else $error("command type wrongly decoded");
    chk_blk_ptr: assert property (@(posedge ref_clk_i) disable iff (!rst_s)
        (state == SCS_CMD && scl_fall && bit_cnt == SCS_BIT_LAST && !start_det && !stop_det
         && !shreg[7]) |=> (ptr == '0 && cnt_phase))
        else $error("block pointer not cleared");
    chk_idx_sel: assert property (@(posedge ref_clk_i) disable iff (!rst_s)
        (state == SCS_CMD && scl_fall && bit_cnt == SCS_BIT_LAST && !start_det && !stop_det
         && shreg[7]) |=> (ptr == $past(shreg[6:0])))
        else $error("byte index not taken");
    chk_wr_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_s)
        (state == SCS_WDATA && scl_fall && bit_cnt == SCS_BIT_LAST && !start_det && !stop_det)
        |=> sda_low)
        else $error("write data not acknowledged");
    chk_ptr_step: assert property (@(posedge ref_clk_i) disable iff (!rst_s)
        (state == SCS_WDATA && scl_fall && bit_cnt == SCS_BIT_LAST && !cnt_phase
         && !start_det && !stop_det) |=> (ptr == $past(ptr) + 1'b1))
        else $error("pointer did not advance");
    chk_stop_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_s)
        stop_det |=> (state == SCS_IDLE && !sda_low))
        else $error("stop not honoured");
    chk_start_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_s)
        start_det |=> (state == SCS_ADDR && bit_cnt == SCS_BIT_PRE && !sda_low))
        else $error("start not taken");
    chk_nack_skip: assert property (@(posedge ref_clk_i) disable iff (!rst_s)
        (state == SCS_RDATA && scl_fall && bit_cnt == SCS_BIT_ACK && host_nack
         && !start_det && !stop_det) |=> (state == SCS_SKIP && !sda_low))
        else $error("read not ended by host nack");
endmodule

// >>> verification/scs_host.sv
// Host model of the two-wire bus: start, stop and nine-bit slots.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/1ps
module scs_host
(
    // Clock and wire
    input  wire logic ref_clk_i,
    input  wire logic sda_i,
    // Host drive
    output logic      scl_o,
    output logic      sda_low_o
);
    initial
    begin
        scl_o     = 1'b1;
        sda_low_o = 1'b0;
    end

    task automatic w(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // Start or repeated start; clock stands high between frames
    task automatic start();
        w(1);
        sda_low_o = 1'b0;
        w(4);
        scl_o = 1'b1;
        w(3);
        sda_low_o = 1'b1;
        w(4);
        scl_o = 1'b0;
    endtask

    // Stop ends any transfer after a whole byte
    task automatic stop();
        w(1);
        sda_low_o = 1'b1;
        w(3);
        scl_o = 1'b1;
        w(3);
        sda_low_o = 1'b0;
        w(4);
    endtask

    // Eight bits MSB first plus acknowledge slot; a 1 releases the wire
    // Low phase of five clocks covers the slave's filtered release of the wire
    task automatic slot(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            w(1);
            sda_low_o = !tx[i];
            w(4);
            scl_o = 1'b1;
            w(2);
            rx[i] = sda_i;
            w(1);
            scl_o = 1'b0;
        end
    endtask
endmodule

// >>> verification/smbus_config_slave_bench.sv
// Self-checking bench for the serial configuration slave.
// Assumes the host model and a pull-up on the data wire.
`timescale 1ns/1ps
module smbus_config_slave_bench
    import scs_pkg::*;
;
    logic                       ref_clk      = 1'b0;
    logic                       rst_b        = 1'b0;
    logic                       power_down_n = 1'b1;
    logic                       scl;
    logic                       sda_low;
    logic                       data_o;
    logic                       data_oe;
    logic                       power_down;
    logic [SCS_NUM_BYTES*8-1:0] cfg;
    logic [8:0]                 rx;
    wire                        sda = !(sda_low || (data_oe && !data_o));
    int                         mismatches = 0;
    int                         num_checks = 0;

    always #20 ref_clk = ~ref_clk;

    scs_slave #(.NUM_BYTES(SCS_NUM_BYTES)) i_scs_slave
    (
        .ref_clk_i            (ref_clk),
        .rst_b_i              (rst_b),
        .serial_clk_i         (scl),
        .serial_data_pin_i    (sda),
        .serial_data_pin_o    (data_o),
        .serial_data_pin_oe_o (data_oe),
        .power_down_n_i       (power_down_n),
        .power_down_o         (power_down),
        .cfg_bytes_o          (cfg)
    );

    scs_host i_scs_host
    (
        .ref_clk_i (ref_clk),
        .sda_i     (sda),
        .scl_o     (scl),
        .sda_low_o (sda_low)
    );

    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [7:0] cb(input int i);
        return cfg[8*i +: 8];
    endfunction

    task automatic put(input logic [7:0] b);
        i_scs_host.slot({b, 1'b1}, rx);
        chk("ack", 9'h000, {8'h00, rx[0]});
    endtask

    task automatic get(input logic ack, input logic [7:0] exp);
        i_scs_host.slot({8'hff, ack}, rx);
        chk("read data", {1'b0, exp}, {1'b0, rx[8:1]});
    endtask

    task automatic hdr(input logic [7:0] cmd);
        i_scs_host.start();
        put({SCS_SLAVE_ADDR, 1'b0});
        put(cmd);
    endtask

    task automatic rhdr();
        i_scs_host.start();
        put({SCS_SLAVE_ADDR, 1'b1});
    endtask

    task automatic t_power();
        chk("pd idle", 9'h000, {8'h00, power_down});
        power_down_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        chk("pd on", 9'h001, {8'h00, power_down});
        power_down_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk("pd off", 9'h000, {8'h00, power_down});
    endtask

    task automatic t_byte();
        hdr(8'h85);
        put(8'ha5);
        i_scs_host.stop();
        chk("cfg5", 9'h0a5, {1'b0, cb(5)});
        chk("cfg4", 9'h0ff, {1'b0, cb(4)});
        hdr(8'h85);
        rhdr();
        get(1'b1, 8'ha5);
        i_scs_host.stop();
    endtask

    task automatic t_word();
        hdr(8'h8a);
        put(8'h34);
        put(8'h12);
        i_scs_host.stop();
        chk("cfg10", 9'h034, {1'b0, cb(10)});
        chk("cfg11", 9'h012, {1'b0, cb(11)});
        hdr(8'h8a);
        rhdr();
        get(1'b0, 8'h34);
        get(1'b1, 8'h12);
        i_scs_host.stop();
    endtask

    task automatic t_block();
        hdr(8'h00);
        put(8'h20);
        for (int i = 0; i < 3; i++) put(8'h11 * (i + 1));
        i_scs_host.stop();
        for (int i = 0; i < 3; i++) chk("blk", 9'h011 * (i + 1), {1'b0, cb(i)});
        chk("cfg3", 9'h0ff, {1'b0, cb(3)});
        hdr(8'h00);
        rhdr();
        get(1'b0, 8'(SCS_NUM_BYTES));
        get(1'b0, 8'h11);
        get(1'b0, 8'h22);
        get(1'b1, 8'h33);
        i_scs_host.stop();
    endtask

    task automatic t_other();
        i_scs_host.start();
        i_scs_host.slot({7'h68, 1'b0, 1'b1}, rx);
        chk("addr nack", 9'h001, {8'h00, rx[0]});
        i_scs_host.slot({8'h8f, 1'b1}, rx);
        chk("cmd nack", 9'h001, {8'h00, rx[0]});
        i_scs_host.slot({8'h00, 1'b1}, rx);
        i_scs_host.stop();
        chk("cfg15", 9'h0ff, {1'b0, cb(15)});
    endtask

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #400us;
        mismatches++;
        finish_test();
    end

    initial
    begin
        repeat (20) @(negedge ref_clk);
        rst_b = 1'b1;
        repeat (12) @(negedge ref_clk);
        for (int i = 0; i < SCS_NUM_BYTES; i++) chk("cfg reset", 9'h0ff, {1'b0, cb(i)});
        t_power();
        t_byte();
        t_word();
        t_block();
        t_other();
        finish_test();
    end
endmodule
